// File: pkg/als_prox_pkg.sv
package als_prox_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [7:0] ADDR_FUNCTION_ENABLE = 8'h80;
    localparam logic [7:0] ADDR_LIGHT_INTEGRATION_TIME = 8'h81;
    localparam logic [7:0] ADDR_PROX_SAMPLE_DURATION = 8'h82;
    localparam logic [7:0] ADDR_LIGHT_WAIT_TIME = 8'h83;

    // Reset values
    localparam logic [7:0] RST_FUNCTION_ENABLE = 8'h00;
    localparam logic [7:0] RST_LIGHT_INTEGRATION_TIME = 8'h00;
    localparam logic [7:0] RST_PROX_SAMPLE_DURATION = 8'h1F;
    localparam logic [7:0] RST_LIGHT_WAIT_TIME = 8'h00;

    // Enable register field positions
    localparam int BIT_POWER_ON = 0;
    localparam int BIT_LIGHT_MEAS_EN = 1;
    localparam int BIT_PROX_MEAS_EN = 2;
    localparam int BIT_LIGHT_WAIT_EN = 3;
    localparam int BIT_PROX_WAIT_EN = 4;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_MHZ = 50;
    // Light step is 2.78 ms, written in microseconds
    localparam int LIGHT_STEP_US = 2780;
    // Proximity sample step is 88 us
    localparam int PROX_STEP_US = 88;
    localparam int LIGHT_STEP_CYCLES = LIGHT_STEP_US * CLK_MHZ;
    localparam int PROX_STEP_CYCLES = PROX_STEP_US * CLK_MHZ;
    // Long-wait option stretches each wait increment by this factor
    localparam logic [3:0] LONG_WAIT_FACTOR = 4'hC;

    // ==========================================================
    // Measurement sequencer states, one-hot
    // ==========================================================
    typedef enum logic [4:0] {
        ST_IDLE      = 5'h01,
        ST_PROX      = 5'h02,
        ST_PROX_WAIT = 5'h04,
        ST_LIGHT_INT = 5'h08,
        ST_LIGHT_WAIT = 5'h10
    } seq_state_t;

endpackage

// File: verilog/step_divider.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Step divider: one-cycle tick every PERIOD clocks
// ==========================================================
module step_divider #(
    parameter int PERIOD = 4400
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic run,
    input wire logic restart,
    output logic tick
);

    // Count kept at 32 bits so long periods fit
    logic [31:0] count_ff;

    // Restart realigns the phase so a new period starts cleanly
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            count_ff <= 32'h0;
        end
        else if (restart || !run)
        begin
            count_ff <= 32'h0;
        end
        else if (count_ff == 32'(PERIOD - 1))
        begin
            count_ff <= 32'h0;
        end
        else
        begin
            count_ff <= count_ff + 32'h1;
        end
    end

    // Tick on the last count; kept under restart, which it may itself cause
    assign tick = run && (count_ff == 32'(PERIOD - 1));

endmodule

`default_nettype wire

// File: verilog/step_down_timer.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Eight-bit down timer with zero as terminal count
// ==========================================================
module step_down_timer (
    input wire logic mclk,
    input wire logic reset,
    input wire logic load,
    input wire logic abort,
    input wire logic [7:0] value,
    input wire logic tick,
    output logic busy,
    output logic done
);

    // Remaining steps
    logic [7:0] count_ff;
    // Running flag
    logic busy_ff;

    // Load starts a run of value plus one steps
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            count_ff <= 8'h00;
            busy_ff <= 1'b0;
        end
        else if (abort)
        begin
            busy_ff <= 1'b0;
        end
        else if (load)
        begin
            count_ff <= value;
            busy_ff <= 1'b1;
        end
        else if (busy_ff && tick)
        begin
            // Terminal count ends the run
            if (count_ff == 8'h00)
            begin
                busy_ff <= 1'b0;
            end
            else
            begin
                count_ff <= count_ff - 8'h01;
            end
        end
    end

    assign busy = busy_ff;
    assign done = busy_ff && tick && !abort && (count_ff == 8'h00);

endmodule

`default_nettype wire

// File: verilog/als_prox_enable_timing.sv
`timescale 1ns/1ns
`default_nettype none

module als_prox_enable_timing #(
    // Clocks per 2.78 ms step; shorten for simulation
    parameter int LIGHT_STEP = als_prox_pkg::LIGHT_STEP_CYCLES,
    // Clocks per 88 us proximity step; shorten for simulation
    parameter int PROX_STEP = als_prox_pkg::PROX_STEP_CYCLES
) (
    input wire logic mclk,
    input wire logic reset,
    // Register port, one access per strobe
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Plain configuration inputs kept outside the register map
    input wire logic long_wait_option,
    input wire logic [7:0] prox_wait_time,
    // Block state
    output logic osc_running,
    output logic prox_sampling,
    output logic prox_waiting,
    output logic light_integrating,
    output logic light_waiting,
    output logic light_cycle_done,
    output logic prox_sample_done
);

    // ==========================================================
    // Register file
    // ==========================================================
    logic [7:0] function_enable_ff; // Enable bits
    logic [7:0] light_integration_time_ff; // Integration steps minus one
    logic [7:0] prox_sample_duration_ff; // Sample steps minus one
    logic [7:0] light_wait_time_ff; // Wait steps minus one
    logic [7:0] reg_rdata_ff; // Read data holding register

    // Decoded enable bits
    logic power_on_bit;
    logic light_meas_enable;
    logic prox_meas_enable;
    logic light_wait_enable;
    logic prox_wait_enable;

    // Address decode used by both the write and the read path
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    // Host writes; reserved enable bits are stored as written
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            function_enable_ff <= als_prox_pkg::RST_FUNCTION_ENABLE;
            light_integration_time_ff <= als_prox_pkg::RST_LIGHT_INTEGRATION_TIME;
            prox_sample_duration_ff <= als_prox_pkg::RST_PROX_SAMPLE_DURATION;
            light_wait_time_ff <= als_prox_pkg::RST_LIGHT_WAIT_TIME;
        end
        else if (reg_wr)
        begin
            // Enable register
            if (hit(reg_addr, als_prox_pkg::ADDR_FUNCTION_ENABLE))
            begin
                function_enable_ff <= reg_wdata;
            end
            // Integration time
            if (hit(reg_addr, als_prox_pkg::ADDR_LIGHT_INTEGRATION_TIME))
            begin
                light_integration_time_ff <= reg_wdata;
            end
            // Proximity sample duration
            if (hit(reg_addr, als_prox_pkg::ADDR_PROX_SAMPLE_DURATION))
            begin
                prox_sample_duration_ff <= reg_wdata;
            end
            // Light wait time
            if (hit(reg_addr, als_prox_pkg::ADDR_LIGHT_WAIT_TIME))
            begin
                light_wait_time_ff <= reg_wdata;
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            reg_rdata_ff <= 8'h00;
        end
        else if (reg_rd)
        begin
            if (hit(reg_addr, als_prox_pkg::ADDR_FUNCTION_ENABLE))
            begin
                reg_rdata_ff <= function_enable_ff;
            end
            else if (hit(reg_addr, als_prox_pkg::ADDR_LIGHT_INTEGRATION_TIME))
            begin
                reg_rdata_ff <= light_integration_time_ff;
            end
            else if (hit(reg_addr, als_prox_pkg::ADDR_PROX_SAMPLE_DURATION))
            begin
                reg_rdata_ff <= prox_sample_duration_ff;
            end
            else if (hit(reg_addr, als_prox_pkg::ADDR_LIGHT_WAIT_TIME))
            begin
                reg_rdata_ff <= light_wait_time_ff;
            end
            else
            begin
                reg_rdata_ff <= 8'h00;
            end
        end
    end

    assign power_on_bit = function_enable_ff[als_prox_pkg::BIT_POWER_ON];
    assign light_meas_enable = function_enable_ff[als_prox_pkg::BIT_LIGHT_MEAS_EN];
    assign prox_meas_enable = function_enable_ff[als_prox_pkg::BIT_PROX_MEAS_EN];
    assign light_wait_enable = function_enable_ff[als_prox_pkg::BIT_LIGHT_WAIT_EN];
    assign prox_wait_enable = function_enable_ff[als_prox_pkg::BIT_PROX_WAIT_EN];

    // ==========================================================
    // Time base
    // ==========================================================
    als_prox_pkg::seq_state_t state_ff; // Sequencer state
    als_prox_pkg::seq_state_t nxt_state; // Next sequencer state
    logic phase_start; // A timed phase begins this cycle
    logic light_tick; // 2.78 ms step
    logic prox_tick; // 88 us step
    logic [3:0] long_cnt_ff; // Sub-step counter for the long-wait option
    logic wait_tick; // Step seen by the shared wait timer

    // Oscillator steps only while powered; restart aligns each phase
    step_divider #(
        .PERIOD(LIGHT_STEP)
    ) u_light_div (
        .mclk(mclk),
        .reset(reset),
        .run(power_on_bit),
        .restart(phase_start),
        .tick(light_tick)
    );

    step_divider #(
        .PERIOD(PROX_STEP)
    ) u_prox_div (
        .mclk(mclk),
        .reset(reset),
        .run(power_on_bit),
        .restart(phase_start),
        .tick(prox_tick)
    );

    // Long option passes only every twelfth light step to the wait timer
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            long_cnt_ff <= 4'h0;
        end
        else if (phase_start || !power_on_bit)
        begin
            long_cnt_ff <= 4'h0;
        end
        else if (light_tick)
        begin
            if (long_cnt_ff == als_prox_pkg::LONG_WAIT_FACTOR - 4'h1)
            begin
                long_cnt_ff <= 4'h0;
            end
            else
            begin
                long_cnt_ff <= long_cnt_ff + 4'h1;
            end
        end
    end

    assign wait_tick = light_tick &&
        (!long_wait_option || long_cnt_ff == als_prox_pkg::LONG_WAIT_FACTOR - 4'h1);

    // ==========================================================
    // Phase timers
    // ==========================================================
    logic stop_all; // Power removed: drop every timer
    logic prox_done; // Proximity sample over
    logic prox_wait_done; // Proximity wait over
    logic int_done; // Integration over
    logic light_wait_done; // Light wait over
    logic [7:0] wait_value; // Value loaded into the shared wait timer
    logic wait_done; // Shared wait timer done

    assign stop_all = !power_on_bit;

    // Proximity sample: (value + 1) steps of 88 us
    step_down_timer u_prox_timer (
        .mclk(mclk),
        .reset(reset),
        .load(phase_start && nxt_state == als_prox_pkg::ST_PROX),
        .abort(stop_all),
        .value(prox_sample_duration_ff),
        .tick(prox_tick),
        .busy(),
        .done(prox_done)
    );

    // Light integration: terminal count zero, value + 1 steps
    step_down_timer u_int_timer (
        .mclk(mclk),
        .reset(reset),
        .load(phase_start && nxt_state == als_prox_pkg::ST_LIGHT_INT),
        .abort(stop_all),
        .value(light_integration_time_ff),
        .tick(light_tick),
        .busy(),
        .done(int_done)
    );

    // Both waits share one timer since they never overlap
    assign wait_value = (nxt_state == als_prox_pkg::ST_LIGHT_WAIT) ?
        light_wait_time_ff : prox_wait_time;

    step_down_timer u_wait_timer (
        .mclk(mclk),
        .reset(reset),
        .load(phase_start && (nxt_state == als_prox_pkg::ST_LIGHT_WAIT ||
            nxt_state == als_prox_pkg::ST_PROX_WAIT)),
        .abort(stop_all),
        .value(wait_value),
        .tick(wait_tick),
        .busy(),
        .done(wait_done)
    );

    assign prox_wait_done = wait_done && state_ff == als_prox_pkg::ST_PROX_WAIT;
    assign light_wait_done = wait_done && state_ff == als_prox_pkg::ST_LIGHT_WAIT;

    // ==========================================================
    // Sequencer
    // ==========================================================
    // Picks the phase after proximity work: light if enabled, else loop
    function automatic als_prox_pkg::seq_state_t after_prox(
        input logic light_en, input logic prox_en);
        if (light_en)
        begin
            after_prox = als_prox_pkg::ST_LIGHT_INT;
        end
        else if (prox_en)
        begin
            after_prox = als_prox_pkg::ST_PROX;
        end
        else
        begin
            after_prox = als_prox_pkg::ST_IDLE;
        end
    endfunction

    // Picks the phase after light work: proximity if enabled, else loop
    function automatic als_prox_pkg::seq_state_t after_light(
        input logic light_en, input logic prox_en);
        if (prox_en)
        begin
            after_light = als_prox_pkg::ST_PROX;
        end
        else if (light_en)
        begin
            after_light = als_prox_pkg::ST_LIGHT_INT;
        end
        else
        begin
            after_light = als_prox_pkg::ST_IDLE;
        end
    endfunction

    // Next-state decode; a running phase completes before enables are seen
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            als_prox_pkg::ST_IDLE:
            begin
                nxt_state = after_light(light_meas_enable, prox_meas_enable);
            end
            als_prox_pkg::ST_PROX:
            begin
                if (prox_done)
                begin
                    if (prox_wait_enable)
                    begin
                        nxt_state = als_prox_pkg::ST_PROX_WAIT;
                    end
                    else
                    begin
                        nxt_state = after_prox(light_meas_enable, prox_meas_enable);
                    end
                end
            end
            als_prox_pkg::ST_PROX_WAIT:
            begin
                if (prox_wait_done)
                begin
                    nxt_state = after_prox(light_meas_enable, prox_meas_enable);
                end
            end
            als_prox_pkg::ST_LIGHT_INT:
            begin
                if (int_done)
                begin
                    if (light_wait_enable)
                    begin
                        nxt_state = als_prox_pkg::ST_LIGHT_WAIT;
                    end
                    else
                    begin
                        nxt_state = after_light(light_meas_enable, prox_meas_enable);
                    end
                end
            end
            als_prox_pkg::ST_LIGHT_WAIT:
            begin
                if (light_wait_done)
                begin
                    nxt_state = after_light(light_meas_enable, prox_meas_enable);
                end
            end
            default:
            begin
                nxt_state = als_prox_pkg::ST_IDLE;
            end
        endcase
        // Power off overrides every enable
        if (!power_on_bit)
        begin
            nxt_state = als_prox_pkg::ST_IDLE;
        end
    end

    // A phase starts whenever the state moves into a timed state
    assign phase_start = power_on_bit && (nxt_state != state_ff ||
        prox_done || int_done || wait_done) && nxt_state != als_prox_pkg::ST_IDLE;

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state_ff <= als_prox_pkg::ST_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // Registered outputs
    // ==========================================================
    logic osc_running_ff;
    logic prox_sampling_ff;
    logic prox_waiting_ff;
    logic light_integrating_ff;
    logic light_waiting_ff;
    logic light_cycle_done_ff;
    logic prox_sample_done_ff;

    // Status follows the next state so it lines up with state_ff
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            osc_running_ff <= 1'b0;
            prox_sampling_ff <= 1'b0;
            prox_waiting_ff <= 1'b0;
            light_integrating_ff <= 1'b0;
            light_waiting_ff <= 1'b0;
            light_cycle_done_ff <= 1'b0;
            prox_sample_done_ff <= 1'b0;
        end
        else
        begin
            osc_running_ff <= power_on_bit;
            prox_sampling_ff <= nxt_state == als_prox_pkg::ST_PROX;
            prox_waiting_ff <= nxt_state == als_prox_pkg::ST_PROX_WAIT;
            light_integrating_ff <= nxt_state == als_prox_pkg::ST_LIGHT_INT;
            light_waiting_ff <= nxt_state == als_prox_pkg::ST_LIGHT_WAIT;
            // Integration result is ready when a step ends with the counter at zero
            light_cycle_done_ff <= int_done && power_on_bit;
            prox_sample_done_ff <= prox_done && power_on_bit;
        end
    end

    assign reg_rdata = reg_rdata_ff;
    assign osc_running = osc_running_ff;
    assign prox_sampling = prox_sampling_ff;
    assign prox_waiting = prox_waiting_ff;
    assign light_integrating = light_integrating_ff;
    assign light_waiting = light_waiting_ff;
    assign light_cycle_done = light_cycle_done_ff;
    assign prox_sample_done = prox_sample_done_ff;

endmodule

`default_nettype wire

// File: test/als_prox_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Port checks for the enable and timing block
// ==========================================================
module als_prox_checker #(
    parameter int LIGHT_STEP = 10,
    parameter int PROX_STEP = 4
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic long_wait_option,
    input wire logic [7:0] prox_wait_time,
    input wire logic osc_running,
    input wire logic prox_sampling,
    input wire logic prox_waiting,
    input wire logic light_integrating,
    input wire logic light_waiting,
    input wire logic light_cycle_done,
    input wire logic prox_sample_done
);
    // One clock domain, all checks quiet in reset
    default clocking dcb @(posedge mclk);
    endclocking
    default disable iff (reset);
    // Phase flags gathered for the exclusivity check
    wire logic [3:0] phase;
    assign phase = {light_waiting, light_integrating, prox_waiting, prox_sampling};
    AST_OSC_FOLLOWS: assert property (reg_wr && reg_addr == 8'h80 |->
        ##2 osc_running == $past(reg_wdata[0], 2)) else $error("oscillator flag off");
    AST_OFF_IDLE: assert property (!osc_running [*2] |-> phase == 4'h0)
        else $error("phase runs while powered off");
    AST_ONE_PHASE: assert property ($onehot0(phase)) else $error("two phases at once");
    AST_INT_DONE: assert property (light_cycle_done |-> $past(light_integrating))
        else $error("light done outside integration");
    AST_DONE_PULSE: assert property (light_cycle_done |=> !light_cycle_done)
        else $error("light done longer than a cycle");
    AST_PDONE_PULSE: assert property (prox_sample_done |=> !prox_sample_done)
        else $error("prox done longer than a cycle");
    AST_PDONE_IN: assert property (prox_sample_done |-> $past(prox_sampling))
        else $error("prox done outside sampling");
    AST_INT_MIN: assert property ($rose(light_integrating) |-> light_integrating [*8])
        else $error("integration too short");
    AST_PROX_MIN: assert property ($rose(prox_sampling) |-> prox_sampling [*4])
        else $error("prox sample too short");
    AST_WAIT_AFTER_INT: assert property ($rose(light_waiting) |-> $past(light_integrating))
        else $error("light wait not after integration");
    AST_UNMAPPED_RD: assert property (reg_rd && reg_addr[7:2] != 6'h20 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    // Main scenarios reached
    cover property ($rose(light_waiting));
    cover property ($rose(prox_waiting));
    cover property (light_cycle_done);
endmodule
`default_nettype wire

// File: test/host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Host side of the register port
// ==========================================================
module host_model (
    input wire logic mclk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // Idle port; address and data show junk when not in use
    initial
    begin
        reg_addr = 8'hFF;
        reg_wdata = 8'hFF;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One write, strobe held for one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        // Enable writes keep the spare bits clear and pair light with prox wait
        if (a == 8'h80)
        begin
            v[7:5] = 3'h0;
            v[4] = v[4] | v[1];
        end
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~v;
    endtask
    // One read; data is taken once the read edge has passed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        d = reg_rdata;
        reg_addr = ~a;
    endtask
endmodule
`default_nettype wire

// File: test/als_prox_enable_timing_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Bench for the enable and timing block
// ==========================================================
module als_prox_enable_timing_tb;
    // Short steps keep the run brief; all counts scale from these
    localparam int LIGHT_STEP = 10;
    localparam int PROX_STEP = 4;
    logic mclk;
    logic reset;
    logic long_wait_option;
    logic [7:0] prox_wait_time;
    wire logic [7:0] reg_addr;
    wire logic [7:0] reg_wdata;
    wire logic reg_wr;
    wire logic reg_rd;
    wire logic [7:0] reg_rdata;
    wire logic osc_running;
    wire logic prox_sampling;
    wire logic prox_waiting;
    wire logic light_integrating;
    wire logic light_waiting;
    wire logic light_cycle_done;
    wire logic prox_sample_done;
    wire logic [3:0] flags;
    int n_errors;
    int check_count;
    assign flags = {light_waiting, light_integrating, prox_waiting, prox_sampling};

    als_prox_enable_timing #(.LIGHT_STEP(LIGHT_STEP), .PROX_STEP(PROX_STEP)) uut (
        .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .long_wait_option(long_wait_option), .prox_wait_time(prox_wait_time),
        .osc_running(osc_running), .prox_sampling(prox_sampling),
        .prox_waiting(prox_waiting), .light_integrating(light_integrating),
        .light_waiting(light_waiting), .light_cycle_done(light_cycle_done),
        .prox_sample_done(prox_sample_done));

    host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // ==========================================================
    // Clock, compare and report
    // ==========================================================
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic close_out();
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Length in cycles of the next full run of one phase flag
    task automatic measure(input int sel, output int n);
        int k;
        k = 0;
        n = 0;
        // Skip a run already under way: it may predate the set-up
        while (flags[sel] === 1'b1 && k < 4000)
        begin
            @(negedge mclk);
            k++;
        end
        while (flags[sel] !== 1'b1 && k < 4000)
        begin
            @(negedge mclk);
            k++;
        end
        while (flags[sel] === 1'b1 && k < 4000)
        begin
            @(negedge mclk);
            n++;
            k++;
        end
        if (k >= 4000)
        begin
            n_errors++;
            $display("MISMATCH phase run expected end seen timeout");
            close_out();
        end
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        logic [7:0] d;
        logic [7:0] rst_tab [4];
        logic [4:0] seen;
        int n;
        rst_tab = '{als_prox_pkg::RST_FUNCTION_ENABLE, als_prox_pkg::RST_LIGHT_INTEGRATION_TIME,
            als_prox_pkg::RST_PROX_SAMPLE_DURATION, als_prox_pkg::RST_LIGHT_WAIT_TIME};
        n_errors = 0;
        check_count = 0;
        reset = 1'b1;
        long_wait_option = 1'b0;
        prox_wait_time = 8'h01;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        // Reset values, unmapped reads and writes
        for (int i = 0; i < 4; i++)
        begin
            host.rd(8'h80 + 8'(i), d);
            chk("reset value", 32'(rst_tab[i]), 32'(d));
        end
        chk("osc after reset", 32'h0, 32'(osc_running));
        host.wr(8'h84, 8'h5A);
        host.rd(8'h84, d);
        chk("unmapped read", 32'h0, 32'(d));
        // Timing registers read back as written
        for (int i = 1; i < 4; i++)
        begin
            host.wr(8'h80 + 8'(i), 8'hA5 ^ 8'(i));
            host.rd(8'h80 + 8'(i), d);
            chk("readback", 32'(8'hA5 ^ 8'(i)), 32'(d));
        end
        // Proximity with the default sample length and a prox wait
        host.wr(8'h82, 8'h1F);
        host.wr(8'h80, 8'h15);
        measure(0, n);
        chk("prox sample", 32'(32 * PROX_STEP), 32'(n));
        measure(1, n);
        chk("prox wait", 32'(2 * LIGHT_STEP), 32'(n));
        chk("light off", 32'h0, 32'(light_integrating));
        // Light cycle: integration then wait
        host.wr(8'h81, 8'h01);
        host.wr(8'h83, 8'h02);
        host.wr(8'h80, 8'h1B);
        measure(2, n);
        chk("integration", 32'(2 * LIGHT_STEP), 32'(n));
        measure(3, n);
        chk("light wait", 32'(3 * LIGHT_STEP), 32'(n));
        chk("osc on", 32'h1, 32'(osc_running));
        // Long wait stretches each increment twelve times
        @(negedge mclk);
        long_wait_option = 1'b1;
        host.wr(8'h83, 8'h00);
        measure(3, n);
        chk("long wait", 32'(12 * LIGHT_STEP), 32'(n));
        // Power off with the light, light wait and prox wait enables still set
        host.wr(8'h80, 8'h1A);
        repeat (3) @(negedge mclk);
        seen = 5'h00;
        repeat (60)
        begin
            @(negedge mclk);
            seen = seen | {light_cycle_done, flags};
        end
        chk("idle when off", 32'h0, 32'(seen));
        chk("osc off", 32'h0, 32'(osc_running));
        close_out();
    end
endmodule

bind als_prox_enable_timing als_prox_checker #(.LIGHT_STEP(LIGHT_STEP), .PROX_STEP(PROX_STEP))
    chk_i (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .long_wait_option(long_wait_option), .prox_wait_time(prox_wait_time),
    .osc_running(osc_running), .prox_sampling(prox_sampling), .prox_waiting(prox_waiting),
    .light_integrating(light_integrating), .light_waiting(light_waiting),
    .light_cycle_done(light_cycle_done), .prox_sample_done(prox_sample_done));
`default_nettype wire
